// File: buck_ctrl_pkg.sv
package buck_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_HZ     = 25_000_000;
  localparam int CLK_NS     = 40;
  localparam int BUCK_HZ    = 300_000;
  localparam int PERIOD     = CLK_HZ / BUCK_HZ;
  localparam int BOOST_DIV  = 3;
  localparam int OC_MIN_NS  = 26_000;
  localparam int OC_MAX_NS  = 53_000;
  localparam int MODE_RUN   = 8;

  localparam logic [6:0]  PERIOD_LAST = 7'(PERIOD - 1);
  localparam logic [6:0]  HALF        = 7'(PERIOD / 2);
  localparam logic [6:0]  PB_OFS      = 7'(PERIOD - PERIOD / 2);
  localparam logic [1:0]  BOOST_LAST  = 2'(BOOST_DIV - 1);
  localparam logic [10:0] OC_MIN_CYC  = 11'((OC_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] OC_MAX_CYC  = 11'(OC_MAX_NS / CLK_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [7:0]  CTRL_OFF    = 8'h00;
  localparam logic [7:0]  STATUS_OFF  = 8'h04;
  localparam int          CTRL_A_BIT  = 0;
  localparam int          CTRL_B_BIT  = 1;
  localparam int          CTRL_BST_BIT = 2;
  localparam int          CTRL_CLR_BIT = 3;
  localparam logic [2:0]  CTRL_RESET  = 3'h7;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic {MODE_PWM, MODE_HYST} mode_t;

  typedef struct packed {
    logic over;
    logic duty_end;
    logic phase_pos;
    logic hyst_lower;
    logic hyst_upper;
    logic droop;
    logic in_window;
    logic under_uv;
    logic high_gs_low;
    logic low_gs_low;
  } chan_sense_t;

  typedef struct packed {
    logic global_enable;
    logic buck_a_enable;
    logic buck_b_enable;
    logic boost_feedback_off;
    logic soft_start_done;
    logic boost_ramp_above;
    logic boost_in_window;
    logic boost_under_uv;
    logic window_pin;
  } misc_sense_t;

  typedef struct packed {
    mode_t       mode;
    logic        quiet;
    logic        pulse;
    logic        low_en;
    logic        blk;
    logic [3:0]  run_cnt;
    logic        oc_act;
    logic [10:0] oc_cnt;
    logic        oc_shut;
    logic        high;
    logic        low;
  } chan_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

endpackage : buck_ctrl_pkg

// File: buck_mode_and_fault_control.sv
`timescale 1ns/1ps
module buck_mode_and_fault_control #(
  parameter int MODE_SAMPLES = buck_ctrl_pkg::MODE_RUN
) (
  // Clock and reset.
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_in,
  // Comparator and pin inputs, asynchronous.
  input  wire buck_ctrl_pkg::chan_sense_t buck_a_sense_in,
  input  wire buck_ctrl_pkg::chan_sense_t buck_b_sense_in,
  input  wire buck_ctrl_pkg::misc_sense_t misc_sense_in,
  // Register bus.
  input  wire buck_ctrl_pkg::axi_req_t axi_in,
  output buck_ctrl_pkg::axi_rsp_t     axi_out,
  // Gate drives.
  output logic                        buck_a_high_gate_out,
  output logic                        buck_a_low_gate_out,
  output logic                        buck_b_high_gate_out,
  output logic                        buck_b_low_gate_out,
  output logic                        boost_gate_out,
  // Supply switches and open-drain power-good.
  output logic                        always_on_out,
  output logic                        feedback_switch_out,
  output logic                        outputs_in_window_out,
  output logic                        outputs_in_window_oe_out
);
  import buck_ctrl_pkg::*;

  if (MODE_SAMPLES < 2 || MODE_SAMPLES > 16) begin : g_bad_samples
    $error("MODE_SAMPLES must lie between 2 and 16");
  end

  localparam logic [3:0] RUN_LAST = 4'(MODE_SAMPLES - 1);

  typedef struct packed {
    chan_sense_t [1:0] s1c;
    chan_sense_t [1:0] s2c;
    misc_sense_t       s1m;
    misc_sense_t       s2m;
    logic [6:0]        cnt;
    logic [1:0]        bdiv;
    logic              boost_gate;
    logic              uv_latch;
    logic              pg;
    logic              pg_oe;
    logic              always_on;
    logic              fb_switch;
    chan_t [1:0]       ch;
    logic [2:0]        ctrl;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    axi_rsp_t          rsp;
  } state_t;

  state_t st;
  state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    chan_t       c;
    chan_sense_t sn;
    logic [6:0]  ph;
    logic [1:0]  en;
    logic        ge;
    logic        clr;
    logic        brun;
    logic        run;
    logic        start;
    logic        last;
    logic        match;
    logic        hreq;
    logic        lreq;
    logic        ctrl_hit;
    c        = '0;
    sn       = '0;
    ph       = '0;
    en       = '0;
    ge       = 1'b0;
    brun     = 1'b0;
    clr      = 1'b0;
    run      = 1'b0;
    start    = 1'b0;
    last     = 1'b0;
    match    = 1'b0;
    hreq     = 1'b0;
    lreq     = 1'b0;
    ctrl_hit = 1'b0;
    next_st  = st;

    // Every pin passes two flops; only the second stage is read below.
    next_st.s1c = {buck_b_sense_in, buck_a_sense_in};
    next_st.s2c = st.s1c;
    next_st.s1m = misc_sense_in;
    next_st.s2m = st.s1m;

    ge    = st.s2m.global_enable;
    en[0] = ge & st.s2m.buck_a_enable & st.ctrl[CTRL_A_BIT];
    en[1] = ge & st.s2m.buck_b_enable & st.ctrl[CTRL_B_BIT];
    // A tied-off boost feedback holds the boost stage idle on its own.
    brun  = ge & en[0] & st.ctrl[CTRL_BST_BIT] & ~st.s2m.boost_feedback_off
            & ~st.uv_latch;

    //////////////////////////////////////////////////////////////////////////
    // Register bus slave.
    if (st.rsp.bvalid && axi_in.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end
    if (st.rsp.rvalid && axi_in.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end
    if (axi_in.awvalid && st.rsp.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = axi_in.awaddr;
    end
    if (axi_in.wvalid && st.rsp.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = axi_in.wdata;
      next_st.wstrb = axi_in.wstrb;
    end
    if (next_st.aw_got && next_st.w_got && !next_st.rsp.bvalid) begin
      ctrl_hit = (next_st.awaddr == CTRL_OFF);
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp  = (ctrl_hit || next_st.awaddr == STATUS_OFF) ?
                           RESP_OKAY : RESP_SLVERR;
      if (ctrl_hit && next_st.wstrb[0]) begin
        next_st.ctrl = next_st.wdata[2:0];
        clr          = next_st.wdata[CTRL_CLR_BIT];
      end
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
    end
    if (axi_in.arvalid && st.rsp.arready) begin
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rresp  = RESP_OKAY;
      next_st.rsp.rdata  = 32'h0;
      if (axi_in.araddr == CTRL_OFF) begin
        next_st.rsp.rdata[2:0] = st.ctrl;
      end else if (axi_in.araddr == STATUS_OFF) begin
        next_st.rsp.rdata[7:0] = {brun, st.s2m.window_pin, st.pg, st.uv_latch,
                                  st.ch[1].oc_shut, st.ch[0].oc_shut,
                                  st.ch[1].mode == MODE_HYST,
                                  st.ch[0].mode == MODE_HYST};
      end else begin
        next_st.rsp.rresp = RESP_SLVERR;
      end
    end
    next_st.rsp.awready = ~next_st.aw_got;
    next_st.rsp.wready  = ~next_st.w_got;
    next_st.rsp.arready = ~next_st.rsp.rvalid;

    //////////////////////////////////////////////////////////////////////////
    // Shared 300 kHz period counter; channel B runs half a period late.
    next_st.cnt = (st.cnt == PERIOD_LAST) ? 7'h00 : st.cnt + 7'h01;

    for (int i = 0; i < 2; i++) begin
      c  = st.ch[i];
      sn = st.s2c[i];
      if (i == 0) begin
        ph = st.cnt;
      end else begin
        ph = (st.cnt >= HALF) ? st.cnt - HALF : st.cnt + PB_OFS;
      end
      start = (ph == 7'h00);
      last  = (ph == PERIOD_LAST);
      if (!ge) begin
        c = '0;
      end
      if (clr) begin
        c.oc_shut = 1'b0;
      end
      run = en[i] & ~c.oc_shut & ~st.uv_latch;
      if (start) begin
        c.quiet  = 1'b0;
        c.blk    = 1'b0;
        c.low_en = 1'b0;
      end

      // Overcurrent timer; a late repeat shuts down, silence clears it.
      if (c.oc_act) begin
        if (sn.over && c.oc_cnt >= OC_MIN_CYC) begin
          c.oc_shut = 1'b1;
          c.oc_act  = 1'b0;
        end else if (c.oc_cnt == OC_MAX_CYC) begin
          c.oc_act  = 1'b0;
        end else begin
          c.oc_cnt  = c.oc_cnt + 11'h001;
        end
      end else if (sn.over && run) begin
        c.oc_act = 1'b1;
        c.oc_cnt = 11'h001;
      end
      if (sn.over) begin
        c.blk = 1'b1;
      end

      // Polarity is sampled in the period's last cycle while the lower switch conducts.
      if (last && st.ch[i].low && run) begin
        match = (sn.phase_pos == (c.mode == MODE_PWM));
        if (!match) begin
          c.run_cnt = 4'h0;
        end else if (c.run_cnt == RUN_LAST) begin
          c.mode    = (c.mode == MODE_PWM) ? MODE_HYST : MODE_PWM;
          c.run_cnt = 4'h0;
          c.quiet   = 1'b1;
        end else begin
          c.run_cnt = c.run_cnt + 4'h1;
        end
      end
      if (c.mode == MODE_HYST && sn.droop) begin
        c.mode    = MODE_PWM;
        c.run_cnt = 4'h0;
        c.quiet   = 1'b1;
      end

      // Pulses open only at the channel's own period start.
      if (start && run && (c.mode == MODE_PWM || sn.hyst_lower)) begin
        c.pulse = 1'b1;
      end
      if (c.pulse && (c.blk || last || c.quiet || !run ||
          (c.mode == MODE_PWM ? sn.duty_end : sn.hyst_upper))) begin
        c.pulse  = 1'b0;
        c.low_en = (c.mode == MODE_HYST);
      end
      // Diode emulation: the low switch drops once current reverses.
      if (c.mode == MODE_HYST && sn.phase_pos) begin
        c.low_en = 1'b0;
      end
      if (c.quiet || !run) begin
        c.pulse  = 1'b0;
        c.low_en = 1'b0;
      end

      hreq = c.pulse;
      lreq = ~c.pulse & ~c.quiet & run &
             ((c.mode == MODE_PWM) | c.low_en);
      // The registered opposite gate closes the monitor's two-flop gap.
      c.high = hreq & sn.low_gs_low & ~st.ch[i].low;
      c.low  = lreq & sn.high_gs_low & ~st.ch[i].high;
      next_st.ch[i] = c;
    end

    //////////////////////////////////////////////////////////////////////////
    // Boost: one buck period in every three, ended by the window's fall.
    if (st.cnt == PERIOD_LAST) begin
      next_st.bdiv = (st.bdiv == BOOST_LAST) ? 2'h0 : st.bdiv + 2'h1;
    end
    next_st.boost_gate = brun & (st.bdiv == 2'h0) &
                         (st.boost_gate | st.s2m.boost_ramp_above);

    //////////////////////////////////////////////////////////////////////////
    // Undervoltage latch and power-good.
    if (clr || !ge) begin
      next_st.uv_latch = 1'b0;
    end
    if (ge && st.s2m.soft_start_done &&
        ((en[0] & st.s2c[0].under_uv) | (en[1] & st.s2c[1].under_uv) |
         (brun & st.s2m.boost_under_uv))) begin
      next_st.uv_latch = 1'b1;
    end
    next_st.pg = ge & st.s2m.soft_start_done & ~st.uv_latch &
                 st.s2c[0].in_window & st.s2c[1].in_window &
                 (~brun | st.s2m.boost_in_window);
    // The pull-down enable gets its own flop so the pin never sees an inverter glitch.
    next_st.pg_oe = ~next_st.pg;
    next_st.always_on = ge;
    next_st.fb_switch = en[0];
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st      <= '0;
      st.ctrl <= CTRL_RESET;
      st.pg_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign axi_out                  = st.rsp;
  assign buck_a_high_gate_out     = st.ch[0].high;
  assign buck_a_low_gate_out      = st.ch[0].low;
  assign buck_b_high_gate_out     = st.ch[1].high;
  assign buck_b_low_gate_out      = st.ch[1].low;
  assign boost_gate_out           = st.boost_gate;
  assign always_on_out            = st.always_on;
  assign feedback_switch_out      = st.fb_switch;
  assign outputs_in_window_out    = st.pg;
  assign outputs_in_window_oe_out = st.pg_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  sequence s_oc_late;
    st.ch[0].oc_act && st.ch[0].oc_cnt >= OC_MIN_CYC && st.s2c[0].over &&
    st.s2m.global_enable;
  endsequence

  sequence s_oc_idle;
    st.ch[0].oc_act && st.ch[0].oc_cnt == OC_MAX_CYC && !st.s2c[0].over;
  endsequence

  sequence s_all_gates_off;
    !buck_a_high_gate_out && !buck_a_low_gate_out &&
    !buck_b_high_gate_out && !buck_b_low_gate_out && !boost_gate_out;
  endsequence

  chk_global_off: assert property (
    !st.s2m.global_enable |=> s_all_gates_off)
    else $error("gates active with global enable low");

  chk_always_on: assert property (
    always_on_out == $past(st.s2m.global_enable))
    else $error("always-on output does not follow global enable");

  chk_buck_a_off: assert property (
    !st.s2m.buck_a_enable |=> !buck_a_high_gate_out && !buck_a_low_gate_out)
    else $error("buck A switching while disabled");

  chk_buck_b_off: assert property (
    !st.s2m.buck_b_enable |=> !buck_b_high_gate_out && !buck_b_low_gate_out)
    else $error("buck B switching while disabled");

  chk_pg_window: assert property (
    !(st.s2c[0].in_window && st.s2c[1].in_window) |=> outputs_in_window_oe_out)
    else $error("power-good released with a buck out of window");

  chk_boost_window: assert property (
    boost_gate_out |-> $past(st.bdiv) == 2'h0)
    else $error("boost gate outside its one-in-three window");

  chk_oc_shutdown: assert property (
    s_oc_late |=> st.ch[0].oc_shut)
    else $error("late overcurrent did not shut buck A down");

  chk_oc_expire: assert property (
    s_oc_idle |=> !st.ch[0].oc_act && !st.ch[0].oc_shut)
    else $error("overcurrent timer not cleared after its interval");

  chk_hyst_entry: assert property (
    $rose(st.ch[0].mode == MODE_HYST) |->
      $past(st.ch[0].run_cnt) == RUN_LAST && $past(st.s2c[0].phase_pos))
    else $error("light-load entered without eight positive samples");

  chk_mode_quiet: assert property (
    $changed(st.ch[0].mode) |-> !buck_a_high_gate_out && !buck_a_low_gate_out)
    else $error("gate on across a mode change");

  chk_droop_exit: assert property (
    st.ch[0].mode == MODE_HYST && st.s2c[0].droop |=> st.ch[0].mode == MODE_PWM)
    else $error("droop did not force fixed-frequency mode");

  chk_no_shoot: assert property (
    buck_a_high_gate_out |-> !buck_a_low_gate_out && $past(!buck_a_low_gate_out))
    else $error("buck A gates overlap");

endmodule : buck_mode_and_fault_control

// File: power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model (
  // Clock and gate drives.
  input  wire logic clk_in,
  input  wire logic high_gate_in,
  input  wire logic low_gate_in,
  // Gate monitors and current comparator.
  output logic      high_gs_low_out,
  output logic      low_gs_low_out,
  output logic      duty_end_out
);
  logic [1:0] high_hist = 2'h0;
  logic [1:0] low_hist  = 2'h0;

  // Gate charge takes two cycles to drain, so the monitor never reports a low gate early.
  always_ff @(posedge clk_in) begin
    high_hist <= {high_hist[0], high_gate_in};
    low_hist  <= {low_hist[0], low_gate_in};
  end

  assign high_gs_low_out = ~(|high_hist) & ~high_gate_in;
  assign low_gs_low_out  = ~(|low_hist) & ~low_gate_in;
  assign duty_end_out    = high_hist[1];
endmodule : power_stage_model

// File: buck_mode_and_fault_control_test.sv
`timescale 1ns/1ps
module buck_mode_and_fault_control_test;
  import buck_ctrl_pkg::*;
  logic        clk_sys_in;
  logic        reset_in;
  chan_sense_t a_ctl, b_ctl, a_sense, b_sense;
  misc_sense_t m_ctl, misc;
  axi_req_t    req;
  axi_rsp_t    rsp;
  logic        a_hi, a_lo, b_hi, b_lo, boost, aon, fbs, oe, pgo;
  logic        a_hgs, a_lgs, a_end, b_hgs, b_lgs, b_end;
  int          error_cnt, n_compared, cyc, a_last, a_gap, ab_gap, a_rises, b_rises;
  int          bst_last, bst_gap, bst_run, bst_max, shoot, overlap;

  // The power-good wire has a pull-up, so its level is the inverse of the pull-down enable.
  assign a_sense = {a_ctl[9], a_end, a_ctl[7:2], a_hgs, a_lgs};
  assign b_sense = {b_ctl[9], b_end, b_ctl[7:2], b_hgs, b_lgs};
  assign misc    = {m_ctl[8:1], ~oe};

  buck_mode_and_fault_control dut (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .buck_a_sense_in(a_sense),
    .buck_b_sense_in(b_sense), .misc_sense_in(misc), .axi_in(req), .axi_out(rsp),
    .buck_a_high_gate_out(a_hi), .buck_a_low_gate_out(a_lo), .buck_b_high_gate_out(b_hi),
    .buck_b_low_gate_out(b_lo), .boost_gate_out(boost), .always_on_out(aon),
    .feedback_switch_out(fbs), .outputs_in_window_out(pgo), .outputs_in_window_oe_out(oe));
  power_stage_model stage_a (.clk_in(clk_sys_in), .high_gate_in(a_hi), .low_gate_in(a_lo),
    .high_gs_low_out(a_hgs), .low_gs_low_out(a_lgs), .duty_end_out(a_end));
  power_stage_model stage_b (.clk_in(clk_sys_in), .high_gate_in(b_hi), .low_gate_in(b_lo),
    .high_gs_low_out(b_hgs), .low_gs_low_out(b_lgs), .duty_end_out(b_end));

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge a_hi) begin
    a_gap = cyc - a_last;
    a_last = cyc;
    a_rises++;
  end
  always @(posedge b_hi) begin
    ab_gap = cyc - a_last;
    b_rises++;
  end
  always @(posedge boost) begin
    bst_gap = cyc - bst_last;
    bst_last = cyc;
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    bst_run = (boost === 1'b1) ? bst_run + 1 : 0;
    if (bst_run > bst_max) bst_max = bst_run;
    if ((a_hi & a_lo) | (b_hi & b_lo)) shoot++;
    if (a_hi & b_hi) overlap++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : idle

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys_in);
      if (req.awvalid && rsp.awready === 1'b1) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (req.wvalid && rsp.wready === 1'b1) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    while (rsp.bvalid !== 1'b1) @(posedge clk_sys_in);
    chk("bresp", 32'(RESP_OKAY), 32'(rsp.bresp));
    req.bready <= 1'b0;
    @(posedge clk_sys_in);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do @(posedge clk_sys_in); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    while (rsp.rvalid !== 1'b1) @(posedge clk_sys_in);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge clk_sys_in);
  endtask : axi_rd

  task automatic stat(input string n, input int i, input logic e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(STATUS_OFF, d, r);
    chk(n, 32'(e), 32'(d[i]));
  endtask : stat

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(CTRL_OFF, d, r);
    chk("ctrl_reset", 32'(CTRL_RESET), d);
    axi_rd(8'h08, d, r);
    chk("unmapped", 32'(RESP_SLVERR), 32'(r));
    axi_wr(CTRL_OFF, 32'h3);
    axi_rd(CTRL_OFF, d, r);
    chk("ctrl_rw", 32'h3, d);
    axi_wr(CTRL_OFF, 32'(CTRL_RESET));
  endtask : t_regs

  task automatic t_global();
    m_ctl.buck_a_enable <= 1'b1;
    m_ctl.buck_b_enable <= 1'b1;
    m_ctl.global_enable <= 1'b0;
    idle(200);
    chk("always_on", 32'h0, 32'(aon));
    chk("rises_off", 32'h0, 32'(a_rises + b_rises));
    m_ctl.global_enable <= 1'b1;
    idle(20);
    chk("always_on", 32'h1, 32'(aon));
  endtask : t_global

  task automatic t_enables();
    m_ctl.buck_b_enable <= 1'b0;
    idle(10);
    a_rises = 0;
    b_rises = 0;
    idle(300);
    chk("a_runs", 32'h1, 32'(a_rises > 0));
    chk("b_held", 32'h0, 32'(b_rises));
    chk("fb_switch", 32'h1, 32'(fbs));
    m_ctl.buck_a_enable <= 1'b0;
    m_ctl.buck_b_enable <= 1'b1;
    idle(10);
    a_rises = 0;
    b_rises = 0;
    idle(300);
    chk("a_held", 32'h0, 32'(a_rises));
    chk("b_runs", 32'h1, 32'(b_rises > 0));
    chk("fb_switch", 32'h0, 32'(fbs));
  endtask : t_enables

  task automatic t_phase();
    m_ctl.buck_a_enable <= 1'b1;
    idle(10);
    shoot = 0;
    overlap = 0;
    idle(400);
    chk("a_period", 32'(PERIOD), 32'(a_gap));
    chk("ab_offset", 32'(HALF), 32'(ab_gap));
    chk("ab_overlap", 32'h0, 32'(overlap));
    chk("shoot", 32'h0, 32'(shoot));
  endtask : t_phase

  task automatic t_boost();
    m_ctl.boost_ramp_above <= 1'b1;
    bst_max = 0;
    idle(800);
    chk("boost_period", 32'(3 * PERIOD), 32'(bst_gap));
    chk("boost_duty", 32'h1, 32'(bst_max <= PERIOD));
    m_ctl.boost_feedback_off <= 1'b1;
    idle(10);
    bst_max = 0;
    idle(300);
    chk("boost_off", 32'h0, 32'(bst_max));
  endtask : t_boost

  task automatic t_overcurrent();
    a_ctl.over <= 1'b1;
    idle(5);
    a_ctl.over <= 1'b0;
    idle(1400);
    a_ctl.over <= 1'b1;
    idle(5);
    a_ctl.over <= 1'b0;
    stat("oc_clear", 2, 1'b0);
    idle(700);
    a_ctl.over <= 1'b1;
    idle(5);
    a_ctl.over <= 1'b0;
    idle(10);
    stat("oc_shut", 2, 1'b1);
    a_rises = 0;
    idle(300);
    chk("oc_gate", 32'h0, 32'(a_rises));
    axi_wr(CTRL_OFF, 32'hF);
    idle(10);
    stat("oc_cleared", 2, 1'b0);
  endtask : t_overcurrent

  task automatic t_mode();
    a_ctl.phase_pos <= 1'b1;
    idle(6 * PERIOD);
    stat("light_early", 0, 1'b0);
    idle(4 * PERIOD);
    stat("light_on", 0, 1'b1);
    a_rises = 0;
    idle(200);
    chk("diode_emul", 32'h0, 32'(a_rises));
    chk("diode_low", 32'h0, 32'(a_lo));
    a_ctl.hyst_lower <= 1'b1;
    idle(200);
    chk("light_pulse", 32'h1, 32'(a_rises > 0));
    chk("light_period", 32'(PERIOD), 32'(a_gap));
    // Upper limit at once ends each pulse, so the low switch conducts at every sample.
    a_ctl.phase_pos <= 1'b0;
    a_ctl.hyst_upper <= 1'b1;
    idle(6 * PERIOD);
    stat("light_hold", 0, 1'b1);
    idle(4 * PERIOD);
    stat("light_off", 0, 1'b0);
    a_ctl.phase_pos <= 1'b1;
    a_ctl.hyst_upper <= 1'b0;
    a_ctl.hyst_lower <= 1'b0;
    idle(10 * PERIOD);
    stat("light_again", 0, 1'b1);
    a_ctl.phase_pos <= 1'b0;
    a_ctl.droop <= 1'b1;
    idle(5);
    stat("droop_exit", 0, 1'b0);
    a_ctl.droop <= 1'b0;
  endtask : t_mode

  task automatic t_power_good();
    a_ctl.in_window <= 1'b1;
    b_ctl.in_window <= 1'b1;
    m_ctl.soft_start_done <= 1'b1;
    idle(20);
    chk("pg_release", 32'h0, 32'(oe));
    chk("pg_level", 32'h1, 32'(pgo));
    b_ctl.in_window <= 1'b0;
    idle(6);
    chk("pg_pull", 32'h1, 32'(oe));
    b_ctl.in_window <= 1'b1;
    a_ctl.under_uv <= 1'b1;
    idle(6);
    stat("uv_latch", 4, 1'b1);
    a_ctl.under_uv <= 1'b0;
    a_rises = 0;
    idle(200);
    chk("uv_gate", 32'h0, 32'(a_rises));
    chk("uv_pg", 32'h1, 32'(oe));
    axi_wr(CTRL_OFF, 32'hF);
    idle(10);
    stat("uv_cleared", 4, 1'b0);
  endtask : t_power_good

  task automatic finish_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    #(40 * 30000);
    error_cnt++;
    finish_test();
  end

  initial begin
    reset_in = 1'b1;
    req = '0;
    a_ctl = '0;
    b_ctl = '0;
    m_ctl = '0;
    m_ctl.global_enable = 1'b1;
    idle(6);
    reset_in <= 1'b0;
    idle(1);
    t_regs();
    t_global();
    t_enables();
    t_phase();
    t_boost();
    t_overcurrent();
    t_mode();
    t_power_good();
    finish_test();
  end
endmodule : buck_mode_and_fault_control_test
